// ### rtl/ccs_top.sv
// Chain command sequencer: device end of a daisy-chain command link.
// Assumes sclk idles high, host drives sdi before each rising edge and
// samples chain_data_down_out on rising edges; registers via AXI4-Lite.
//
// Overview of operation
// (R1) Frame: addr, reg, data, all, zero, crc, 010
// (R2) Read-off bits both set: readback returns nothing
// (R3) Host disables all reads, enables target only
// (R4) Host loads read-select before readback
// (R5) Readback frame is 32 clocks, contents out
// (R6) Host keeps single-part readback clock below 1MHz; the bench host model clocks sclk at 12.5MHz
// (R7) Mode bits 1100 select self-test conversion
// (R8) Chain-read bit enables register readback
// (R9) Convert control 0x02 enables pin starts
// (R10) Pin falling edge starts conversion sequence
// (R11) Host waits conversions plus settle time
// (R12) Convert control 0x01 gates pin, loads outputs; output_load pulses only for a chain-frame write, not an AXI write
// (R13) Software reset bit holds device in reset
// (R14) Read-select is zero after any reset
// (R15) Host sends frames one at a time
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"

module ccs_top
	import ccs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic chain_data_down_out,
	input wire logic convert_start_pin,
	output logic conv_launch,
	output logic conv_busy,
	output logic selftest_sel,
	output logic soft_reset,
	output logic output_load
);

	logic [4:0] bit_cnt, next_bit_cnt, tx_cnt, next_tx_cnt;
	logic [31:0] rx_sh, next_rx_sh, rx_word, next_rx_word;
	logic [31:0] tx_sh, next_tx_sh, tx_word, next_tx_word;
	logic rx_tog, next_rx_tog, next_sdo, link_rst;
	logic tog_s, cs_s, pin_s, tog_d, pin_d, frame_new, pin_fall;
	logic [7:0] ctrl_hi, next_ctrl_hi, ctrl_lo, next_ctrl_lo;
	logic [7:0] read_sel, next_read_sel, cnv_ctrl, next_cnv_ctrl;
	logic [7:0] frames, next_frames;
	logic [4:0] dev_addr, next_dev_addr;
	logic fmt_err, next_fmt_err, next_output_load;
	logic next_soft_reset, next_selftest_sel;
	ccs_frame_t fr;
	ccs_rb_t rb;
	logic fmt_ok, is_rb, fr_hit, launch;
	logic [32:0] sel_val, rd_val, wr_val;
	logic aw_got, next_aw_got, w_got, next_w_got, w_strb0, next_w_strb0;
	logic [5:0] aw_idx, next_aw_idx;
	logic [31:0] w_data, next_w_data, next_rdata;
	logic next_awready, next_wready, next_bvalid, axi_wr;
	logic next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	ccs_cv_t cv_state, next_cv_state;
	logic [11:0] cv_cnt, next_cv_cnt;
	logic next_conv_launch, next_conv_busy;

	// Register view: top bit marks a mapped index
	function automatic logic [32:0] reg_val(input logic [5:0] idx);
		logic [32:0] v;
		v = '0;
		case (idx)
			`CCS_IDX_CTRL_HI: v = {1'b1, 24'h0, ctrl_hi};
			`CCS_IDX_CTRL_LO: v = {1'b1, 24'h0, ctrl_lo};
			`CCS_IDX_READ_SEL: v = {1'b1, 24'h0, read_sel};
			`CCS_IDX_CNV_CTRL: v = {1'b1, 24'h0, cnv_ctrl};
			`CCS_IDX_DEV_ADDR: v = {1'b1, 27'h0, dev_addr};
			`CCS_IDX_STATUS: begin
				v = {1'b1, 32'h0};
				v[`CCS_ST_BUSY] = conv_busy;
				v[`CCS_ST_SELFTEST] = selftest_sel;
				v[`CCS_ST_FMT_ERR] = fmt_err;
				v[`CCS_ST_SRST] = soft_reset;
				v[`CCS_ST_FRAMES] = frames;
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	// Link side, receive on rising sclk; cs_n high resynchronises
	always_comb begin
		next_bit_cnt = bit_cnt + 5'h01;
		next_rx_sh = {rx_sh[30:0], sdi};
		next_rx_word = rx_word;
		next_rx_tog = rx_tog;
		// (R5) Whole 32-clock frame
		if (bit_cnt == `CCS_BIT_LAST) begin
			next_rx_word = next_rx_sh;
			next_rx_tog = ~rx_tog;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= `CCS_BIT_FIRST;
			rx_sh <= 32'h0;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx_sh <= next_rx_sh;
		end
	end

	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			rx_word <= 32'h0;
			rx_tog <= 1'b0;
		end else begin
			rx_word <= next_rx_word;
			rx_tog <= next_rx_tog;
		end
	end

	// Link side, transmit on falling sclk
	always_comb begin
		next_tx_cnt = tx_cnt + 5'h01;
		// (R5) Contents out, MSB first
		if (tx_cnt == `CCS_BIT_FIRST) begin
			next_sdo = tx_word[31];
			next_tx_sh = {tx_word[30:0], 1'b0};
		end else begin
			next_sdo = tx_sh[31];
			next_tx_sh = {tx_sh[30:0], 1'b0};
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_cnt <= `CCS_BIT_FIRST;
			tx_sh <= 32'h0;
			chain_data_down_out <= 1'b0;
		end else begin
			tx_cnt <= next_tx_cnt;
			tx_sh <= next_tx_sh;
			chain_data_down_out <= next_sdo;
		end
	end

	ccs_sync #(
		.WIDTH(3)
	) i_ccs_sync (
		.clk(aclk),
		.rst_n(aresetn),
		.d({rx_tog, cs_n, convert_start_pin}),
		.q({tog_s, cs_s, pin_s})
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_rst <= 1'b1;
			tog_d <= 1'b0;
			pin_d <= 1'b0;
		end else begin
			link_rst <= 1'b0;
			tog_d <= tog_s;
			pin_d <= pin_s;
		end
	end

	assign frame_new = tog_s ^ tog_d;
	assign pin_fall = pin_d & ~pin_s;

	// Frame decode
	assign fr = ccs_frame_t'(rx_word);
	// (R1) Zero bit and tail checked
	assign fmt_ok = (fr.tail == `CCS_FRAME_TAIL) && !fr.zero;
	assign is_rb = (fr.dev == `CCS_RB_DEV) && !fr.wall;
	assign fr_hit = frame_new && fmt_ok && !is_rb &&
		(fr.wall || (fr.dev == dev_addr));
	assign axi_wr = aw_got && w_got && !s_axi_bvalid;

	// Register file
	always_comb begin
		next_ctrl_hi = ctrl_hi;
		next_ctrl_lo = ctrl_lo;
		next_read_sel = read_sel;
		next_cnv_ctrl = cnv_ctrl;
		next_dev_addr = dev_addr;
		next_fmt_err = fmt_err;
		next_frames = frames;
		next_tx_word = tx_word;
		next_output_load = 1'b0;
		// Evaluated here so register changes are seen
		sel_val = reg_val(read_sel[`CCS_SEL_IDX]);
		rb = '{dev: dev_addr, idx: read_sel[`CCS_SEL_IDX],
			data: sel_val[7:0], pad: 13'h0};
		if (axi_wr && w_strb0) begin
			unique case (aw_idx)
				`CCS_IDX_CTRL_HI: next_ctrl_hi = w_data[7:0];
				`CCS_IDX_CTRL_LO: next_ctrl_lo = w_data[7:0];
				`CCS_IDX_READ_SEL: next_read_sel = w_data[7:0];
				`CCS_IDX_CNV_CTRL: next_cnv_ctrl = w_data[7:0];
				`CCS_IDX_DEV_ADDR: next_dev_addr = w_data[4:0];
				`CCS_IDX_STATUS: begin
					if (w_data[`CCS_ST_FMT_ERR])
						next_fmt_err = 1'b0;
				end
				default: next_frames = frames;
			endcase
		end
		if (fr_hit) begin
			unique case (fr.idx)
				`CCS_IDX_CTRL_HI: next_ctrl_hi = fr.data;
				`CCS_IDX_CTRL_LO: next_ctrl_lo = fr.data;
				`CCS_IDX_READ_SEL: next_read_sel = fr.data;
				`CCS_IDX_CNV_CTRL: next_cnv_ctrl = fr.data;
				default: next_frames = frames;
			endcase
		end
		// (R12) Gate write loads outputs
		if (fr_hit && (fr.idx == `CCS_IDX_CNV_CTRL) &&
			(fr.data == `CCS_CNV_GATE))
			next_output_load = 1'b1;
		if (frame_new && !fmt_ok)
			next_fmt_err = 1'b1;
		if (frame_new)
			next_frames = frames + 8'h01;
		// (R14) Read-select cleared in reset
		if (ctrl_lo[`CCS_LO_SRST])
			next_read_sel = `CCS_RST_READ_SEL;
		// (R13) Software reset held
		next_soft_reset = ctrl_lo[`CCS_LO_SRST];
		// (R7) Self-test mode decode
		next_selftest_sel = (ctrl_hi[`CCS_HI_MODE] == `CCS_SELFTEST);
		// (R2) (R8) Readback content or silence
		if (cs_s) begin
			if (ctrl_lo[`CCS_LO_CHAIN_RD] &&
				(ctrl_hi[`CCS_HI_READ] != `CCS_RB_MUTE))
				next_tx_word = rb;
			else
				next_tx_word = 32'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_hi <= `CCS_RST_CTRL;
			ctrl_lo <= `CCS_RST_CTRL;
			read_sel <= `CCS_RST_READ_SEL;
			cnv_ctrl <= `CCS_RST_CNV_CTRL;
			dev_addr <= `CCS_RST_DEV_ADDR;
			fmt_err <= 1'b0;
			frames <= 8'h00;
			tx_word <= 32'h0;
			output_load <= 1'b0;
			soft_reset <= 1'b0;
			selftest_sel <= 1'b0;
		end else begin
			ctrl_hi <= next_ctrl_hi;
			ctrl_lo <= next_ctrl_lo;
			read_sel <= next_read_sel;
			cnv_ctrl <= next_cnv_ctrl;
			dev_addr <= next_dev_addr;
			fmt_err <= next_fmt_err;
			frames <= next_frames;
			tx_word <= next_tx_word;
			output_load <= next_output_load;
			soft_reset <= next_soft_reset;
			selftest_sel <= next_selftest_sel;
		end
	end

	// Conversion sequencer
	always_comb begin
		// (R9) (R10) Enabled pin falling edge
		launch = pin_fall && (cnv_ctrl == `CCS_CNV_PIN_EN) &&
			!ctrl_lo[`CCS_LO_SRST] && (cv_state == CCS_CV_IDLE);
		next_cv_state = cv_state;
		next_cv_cnt = cv_cnt;
		unique case (cv_state)
			CCS_CV_IDLE: begin
				if (launch) begin
					next_cv_state = CCS_CV_RUN;
					next_cv_cnt = 12'(`CCS_CONV_CYC - 1);
				end
			end
			CCS_CV_RUN: begin
				if (ctrl_lo[`CCS_LO_SRST] || (cv_cnt == 12'h000))
					next_cv_state = CCS_CV_IDLE;
				else
					next_cv_cnt = cv_cnt - 12'h001;
			end
		endcase
		next_conv_launch = launch;
		next_conv_busy = (next_cv_state == CCS_CV_RUN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cv_state <= CCS_CV_IDLE;
			cv_cnt <= 12'h000;
			conv_launch <= 1'b0;
			conv_busy <= 1'b0;
		end else begin
			cv_state <= next_cv_state;
			cv_cnt <= next_cv_cnt;
			conv_launch <= next_conv_launch;
			conv_busy <= next_conv_busy;
		end
	end

	// AXI4-Lite slave
	always_comb begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_idx = aw_idx;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		wr_val = reg_val(aw_idx);
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got = 1'b1;
			next_aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb0 = s_axi_wstrb[0];
		end
		if (axi_wr) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_val[32] ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_got && !next_bvalid;
		next_wready = !next_w_got && !next_bvalid;
		rd_val = reg_val(s_axi_araddr[7:2]);
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_val[31:0];
			next_rresp = rd_val[32] ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_idx <= 6'h00;
			w_data <= 32'h0;
			w_strb0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `CCS_RESP_OKAY;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_idx <= next_aw_idx;
			w_data <= next_w_data;
			w_strb0 <= next_w_strb0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_fmt_err; // (R1)
		frame_new && !fmt_ok |=> fmt_err [*2];
	endproperty
	a_fmt_err: assert property (p_fmt_err) // (R1)
		else $error("bad frame unflagged");

	property p_rb_mute; // (R2)
		cs_s && (ctrl_hi[`CCS_HI_READ] == `CCS_RB_MUTE) |=> tx_word == 32'h0;
	endproperty
	a_rb_mute: assert property (p_rb_mute) // (R2)
		else $error("muted readback");

	property p_frame_len; // (R5)
		@(posedge sclk) disable iff (link_rst)
		(bit_cnt == `CCS_BIT_LAST) |=> rx_tog != $past(rx_tog);
	endproperty
	a_frame_len: assert property (p_frame_len) // (R5)
		else $error("frame lost");

	property p_selftest; // (R7)
		ctrl_hi[`CCS_HI_MODE] == `CCS_SELFTEST |=> selftest_sel;
	endproperty
	a_selftest: assert property (p_selftest) // (R7)
		else $error("self-test missed");

	property p_rb_dev; // (R8)
		cs_s && ctrl_lo[`CCS_LO_CHAIN_RD] &&
		(ctrl_hi[`CCS_HI_READ] != `CCS_RB_MUTE)
		|=> tx_word[31:27] == $past(dev_addr);
	endproperty
	a_rb_dev: assert property (p_rb_dev) // (R8)
		else $error("readback address");

	property p_pin_gate; // (R9)
		pin_fall && (cnv_ctrl != `CCS_CNV_PIN_EN) |=> !conv_launch;
	endproperty
	a_pin_gate: assert property (p_pin_gate) // (R9)
		else $error("gated launch");

	property p_launch; // (R10)
		launch |=> conv_launch && conv_busy ##1 !conv_launch && conv_busy;
	endproperty
	a_launch: assert property (p_launch) // (R10)
		else $error("launch missed");

	property p_load; // (R12)
		fr_hit && (fr.idx == `CCS_IDX_CNV_CTRL) &&
		(fr.data == `CCS_CNV_GATE) |=> output_load ##1 !output_load;
	endproperty
	a_load: assert property (p_load) // (R12)
		else $error("output load missed");

	property p_srst; // (R13)
		ctrl_lo[`CCS_LO_SRST] |=> soft_reset && !conv_launch;
	endproperty
	a_srst: assert property (p_srst) // (R13)
		else $error("soft reset missed");

	property p_rsel; // (R14)
		soft_reset |-> read_sel == `CCS_RST_READ_SEL;
	endproperty
	a_rsel: assert property (p_rsel) // (R14)
		else $error("read-select not clear");

	c_frame_write: cover property (fr_hit);
	c_launch: cover property (conv_launch ##[1:10] conv_busy);
	c_readback: cover property (frame_new && is_rb && fmt_ok);
	c_axi_rd: cover property (s_axi_rvalid && s_axi_rready);

endmodule

`default_nettype wire

// ### rtl/ccs_regs.svh
// Chain command sequencer: register indices, field places, reset values
// and timing counts. Included by the top module and the bench files; definitions only.
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// Register indices; AXI byte address is four times the index
`define CCS_IDX_CTRL_HI 6'h0d
`define CCS_IDX_CTRL_LO 6'h0e
`define CCS_IDX_READ_SEL 6'h1c
`define CCS_IDX_CNV_CTRL 6'h1d
`define CCS_IDX_DEV_ADDR 6'h30
`define CCS_IDX_STATUS 6'h31

// Reset values
`define CCS_RST_CTRL 8'h00
`define CCS_RST_READ_SEL 8'h00
`define CCS_RST_CNV_CTRL 8'h00
`define CCS_RST_DEV_ADDR 5'h00

// Field places
`define CCS_HI_CONV 7:6
`define CCS_HI_READ 5:4
`define CCS_HI_MODE 7:4
`define CCS_LO_SRST 7
`define CCS_LO_CHAIN_RD 0
`define CCS_SEL_IDX 7:2
`define CCS_ST_BUSY 0
`define CCS_ST_SELFTEST 1
`define CCS_ST_FMT_ERR 2
`define CCS_ST_SRST 3
`define CCS_ST_FRAMES 15:8

// Field values
`define CCS_CNV_PIN_EN 8'h02
`define CCS_CNV_GATE 8'h01
`define CCS_FRAME_TAIL 3'h2
`define CCS_RB_DEV 5'h1f
`define CCS_RB_MUTE 2'h3
`define CCS_SELFTEST 4'hc
`define CCS_RESP_OKAY 2'h0
`define CCS_RESP_SLVERR 2'h2

// Frame bit counter
`define CCS_BIT_FIRST 5'h00
`define CCS_BIT_LAST 5'h1f

// Conversion sequence time
`define CCS_CONV_NS 12000
`define CCS_CLK_NS 5
`define CCS_CONV_CYC ((`CCS_CONV_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)

`endif

// ### rtl/ccs_pkg.sv
// Chain command sequencer: shared types.
// Assumes nothing of its surroundings.
`default_nettype none

package ccs_pkg;

	typedef struct packed {
		logic [4:0] dev;
		logic [5:0] idx;
		logic [7:0] data;
		logic wall;
		logic zero;
		logic [7:0] crc;
		logic [2:0] tail;
	} ccs_frame_t;

	typedef struct packed {
		logic [4:0] dev;
		logic [5:0] idx;
		logic [7:0] data;
		logic [12:0] pad;
	} ccs_rb_t;

	typedef enum logic {
		CCS_CV_IDLE = 1'b0,
		CCS_CV_RUN = 1'b1
	} ccs_cv_t;

endpackage

`default_nettype wire

// ### rtl/ccs_sync.sv
// Chain command sequencer: two-flop synchroniser for level signals.
// Assumes inputs are levels held for at least two clock cycles.
`timescale 1ns/1ps
`default_nettype none

module ccs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

`default_nettype wire

// ### tb/ccs_host_model.sv
// Host end of the serial chain link: builds and shifts command frames.
// Assumes the device samples sdi on rising sclk and drives on falling.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"

module ccs_host_model
	import ccs_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	function automatic logic [31:0] frame(input logic [4:0] dev,
		input logic [5:0] idx, input logic [7:0] data, input logic wall);
		ccs_frame_t f;
		f = '{dev, idx, data, wall, 1'b0, 8'h00, `CCS_FRAME_TAIL};
		return f;
	endfunction

	task automatic shift(input logic [31:0] tx, input int n,
		output logic [31:0] rx);
		#7.3 cs_n = 1'b0;
		#100;
		for (int k = 0; k < n; k++) begin
			sclk = 1'b0;
			sdi = tx[31-k];
			#40 sclk = 1'b1;
			rx = {rx[30:0], dout};
			#40;
		end
		cs_n = 1'b1;
		// Released line shows no stale bit
		sdi = ~sdi;
		#200;
	endtask
endmodule

`default_nettype wire

// ### tb/tb_chain_cmd_sequencer.sv
// Bench for the chain command sequencer: AXI4-Lite register access
// and serial command frames from the host model; self-checking.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"

module tb_chain_cmd_sequencer
	import ccs_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rxw;
	logic sclk, cs_n, sdi, dout;
	logic cnv_pin = 1'b1;
	logic [3:0] strb = 4'hf;
	logic launch, busy, stsel, srst, oload;
	int checks = 0, err_total = 0;
	int n_launch = 0, n_busy = 0, n_load = 0;

	always #2.5 aclk = ~aclk;

	always @(posedge aclk) begin
		if (launch === 1'b1) n_launch++;
		if (busy === 1'b1) n_busy++;
		if (oload === 1'b1) n_load++;
	end

	ccs_top i_ccs_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(w_v), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(b_r),
		.s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(r_r),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .chain_data_down_out(dout),
		.convert_start_pin(cnv_pin), .conv_launch(launch),
		.conv_busy(busy), .selftest_sel(stsel), .soft_reset(srst),
		.output_load(oload)
	);

	ccs_host_model i_ccs_host_model (
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .dout(dout)
	);

	task automatic stop_test();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic hang(input string nm);
		err_total++;
		$display("MISMATCH %s exp done got timeout", nm);
		stop_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) aw_v <= 1'b0;
			if (wready) w_v <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang("axi write");
		r = bresp;
		b_r <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) ar_v <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang("axi read");
		d = rdata;
		r = rresp;
		r_r <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, e, d);
		chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
	endtask

	task automatic fw(input logic [4:0] dv, input logic [5:0] ix,
		input logic [7:0] dt, input logic wa);
		i_ccs_host_model.shift(i_ccs_host_model.frame(dv, ix, dt, wa),
			32, rxw);
	endtask

	task automatic rb();
		i_ccs_host_model.shift(32'hf800030a, 32, rxw);
	endtask

	initial begin
		logic [1:0] r;
		logic [31:0] d, good;
		int n;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		rchk("read_sel", 8'h70, 32'h0, 2'h0);
		rchk("cnv_ctrl", 8'h74, 32'h0, 2'h0);
		rchk("unmapped", 8'h00, 32'h0, 2'h2);
		wr(8'h00, 32'h5a, r);
		chk("wr unmapped", 32'h2, {30'h0, r});
		wr(8'hc0, 32'h10, r);
		chk("wr dev", 32'h0, {30'h0, r});
		fw(5'h00, 6'h0d, 8'h30, 1'b1);
		fw(5'h00, 6'h0e, 8'h01, 1'b1);
		fw(5'h10, 6'h1c, 8'h38, 1'b0);
		rb();
		chk("muted word", 32'h0, rxw);
		fw(5'h10, 6'h0d, 8'h00, 1'b0);
		fw(5'h03, 6'h1c, 8'h0c, 1'b0);
		rb();
		chk("readback", {5'h10, 6'h0e, 8'h01, 13'h0}, rxw);
		rchk("ctrl_lo", 8'h38, 32'h1, 2'h0);
		rchk("read_sel", 8'h70, 32'h38, 2'h0);
		fw(5'h00, 6'h0d, 8'hc0, 1'b1);
		chk("selftest", 32'h1, {31'h0, stsel});
		fw(5'h00, 6'h1d, 8'h02, 1'b1);
		@(posedge aclk) cnv_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		chk("launch", 32'h1, n_launch);
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge aclk);
		if (n == 3000) hang("conversion");
		chk("busy cycles", `CCS_CONV_CYC, n_busy);
		@(posedge aclk) cnv_pin <= 1'b1;
		fw(5'h00, 6'h1d, 8'h01, 1'b1);
		chk("load", 32'h1, n_load);
		@(posedge aclk) cnv_pin <= 1'b0;
		repeat (10) @(posedge aclk);
		chk("gated", 32'h1, n_launch);
		@(posedge aclk) cnv_pin <= 1'b1;
		fw(5'h00, 6'h0e, 8'h80, 1'b1);
		chk("srst on", 32'h1, {31'h0, srst});
		rchk("read_sel srst", 8'h70, 32'h0, 2'h0);
		fw(5'h00, 6'h0e, 8'h00, 1'b1);
		chk("srst off", 32'h0, {31'h0, srst});
		rb();
		chk("chain off", 32'h0, rxw);
		wr(8'h70, 32'h38, r);
		rchk("read_sel axi", 8'h70, 32'h38, 2'h0);
		// Lane 0 disabled: write answered but dropped
		strb <= 4'h0;
		wr(8'h70, 32'h11, r);
		strb <= 4'hf;
		chk("wr strb", 32'h0, {30'h0, r});
		rchk("read_sel strb", 8'h70, 32'h38, 2'h0);
		good = i_ccs_host_model.frame(5'h00, 6'h1c, 8'h44, 1'b1);
		i_ccs_host_model.shift(good ^ 32'h1, 32, rxw);
		i_ccs_host_model.shift(good ^ 32'h800, 32, rxw);
		i_ccs_host_model.shift(good, 31, rxw);
		rchk("read_sel bad", 8'h70, 32'h38, 2'h0);
		rd(8'hc4, d, r);
		chk("fmt_err", 32'h4, d & 32'h4);
		stop_test();
	end
endmodule

`default_nettype wire
